/* rtl/ubgp_port.v */
// Four-pin general purpose port with AXI4-Lite registers
`timescale 1ns/1ps
`include "ubgp_consts.vh"

module ubgp_port
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  // Device configuration mode
  input wire [1:0] config_mode,
  // Stored trigger edge parameter, 1 selects falling
  input wire nv_edge_fall,
  // Write address channel
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // Write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // Write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // Read address channel
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // Read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Port pins
  input wire [3:0] general_io_i,
  output reg [3:0] general_io_o,
  output reg [3:0] general_io_oe,
  // Alternate function selects per pin
  output reg [11:0] pin_func,
  // Interrupt
  output reg irq
);

  // ------------------------------------------------------------
  // State and decode nets
  // ------------------------------------------------------------
  reg [1:0] mode_q;
  reg irq_en_q;
  reg fall_q;
  reg [3:0] dir_q;
  reg [3:0] out_q;
  reg [11:0] func_q;
  reg stat_q;
  reg mask_q;
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg [3:0] prev_q;
  reg [11:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  reg fall_seen_q;

  wire pipe_on;
  wire [3:0] gpio_pin;
  wire irq_pin;
  wire edge_hit;
  wire wr_go;
  wire wr_mapped;
  wire wr_ctrl;
  wire wr_dir;
  wire wr_out;
  wire wr_func;
  wire wr_stat;
  wire wr_mask;
  wire stat_d;
  reg [31:0] rd_word;
  reg rd_ok;
  wire [11:0] rd_addr;

  // ------------------------------------------------------------
  // Pipe and pin decode
  // ------------------------------------------------------------
  // Pipe open only in the two port modes
  assign pipe_on = (mode_q == `UBGP_MODE_ZERO) || (mode_q == `UBGP_MODE_ONE);

  // Code 0 in a function field means plain general I/O
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_pin
      assign gpio_pin[g] = (func_q[3*g+2:3*g] == `UBGP_FN_GPIO);
    end
  endgenerate

  assign irq_pin = (func_q[11:9] == `UBGP_FN_IRQ) && irq_en_q;
  // The second stage and its delayed copy in prev_q feed the edge compare
  assign edge_hit = irq_pin && pipe_on &&
                    (fall_q ? (prev_q[3] & ~sync2_q[3]) : (~prev_q[3] & sync2_q[3]));

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  // Write path: address and data captured in either order
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_ctrl = wr_go && (awaddr_q == `UBGP_OFF_CTRL);
  assign wr_dir = wr_go && (awaddr_q == `UBGP_OFF_DIR) && pipe_on;
  assign wr_out = wr_go && (awaddr_q == `UBGP_OFF_OUT) && pipe_on;
  assign wr_func = wr_go && (awaddr_q == `UBGP_OFF_FUNC) && pipe_on;
  assign wr_stat = wr_go && (awaddr_q == `UBGP_OFF_STAT);
  assign wr_mask = wr_go && (awaddr_q == `UBGP_OFF_MASK);
  assign wr_mapped = wr_ctrl || wr_stat || wr_mask ||
                     (pipe_on && ((awaddr_q == `UBGP_OFF_DIR) || (awaddr_q == `UBGP_OFF_OUT) ||
                     (awaddr_q == `UBGP_OFF_FUNC) || (awaddr_q == `UBGP_OFF_IN)));

  // New edges win over a clear in the same cycle
  assign stat_d = edge_hit || (stat_q && !(wr_stat && wstrb_q[0] && wdata_q[`UBGP_STAT_EDGE_BIT]));

  // ------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------
  // Low address bits ignored, as on the write side
  assign rd_addr = {s_axi_araddr[11:2], 2'b00};

  always @*
  begin
    rd_word = `UBGP_RST_WORD;
    rd_ok = 1'b1;
    case (rd_addr)
      `UBGP_OFF_CTRL:
      begin
        rd_word[`UBGP_CTRL_MODE_MSB:`UBGP_CTRL_MODE_LSB] = mode_q;
        rd_word[`UBGP_CTRL_IRQ_EN_BIT] = irq_en_q;
        rd_word[`UBGP_CTRL_FALL_BIT] = fall_q;
      end
      `UBGP_OFF_DIR:
      begin
        rd_word[3:0] = dir_q;
        rd_ok = pipe_on;
      end
      `UBGP_OFF_OUT:
      begin
        rd_word[3:0] = out_q;
        rd_ok = pipe_on;
      end
      `UBGP_OFF_IN:
      begin
        rd_word[3:0] = sync2_q;
        rd_ok = pipe_on;
      end
      `UBGP_OFF_FUNC:
      begin
        rd_word[11:0] = func_q;
        rd_ok = pipe_on;
      end
      `UBGP_OFF_STAT: rd_word[`UBGP_STAT_EDGE_BIT] = stat_q;
      `UBGP_OFF_MASK: rd_word[`UBGP_STAT_EDGE_BIT] = mask_q;
      default: rd_ok = 1'b0;
    endcase
    if (!rd_ok)
    begin
      rd_word = `UBGP_RST_WORD;
    end
  end

  // ------------------------------------------------------------
  // Clocked state
  // ------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q <= `UBGP_RST_MODE;
      irq_en_q <= 1'b0;
      fall_q <= 1'b0;
      fall_seen_q <= 1'b0;
      dir_q <= 4'h0;
      out_q <= 4'h0;
      func_q <= `UBGP_RST_FUNC;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q <= 4'h0;
      awaddr_q <= 12'h000;
      aw_have_q <= 1'b0;
      wdata_q <= `UBGP_RST_WORD;
      wstrb_q <= 4'h0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UBGP_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `UBGP_RESP_OKAY;
      s_axi_rdata <= `UBGP_RST_WORD;
      general_io_o <= 4'h0;
      general_io_oe <= 4'h0;
      pin_func <= `UBGP_RST_FUNC;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      // Mode and stored edge caught after reset release, not under reset
      mode_q <= config_mode;
      if (!fall_seen_q)
      begin
        fall_q <= nv_edge_fall;
        fall_seen_q <= 1'b1;
      end
      // ------------------------------------------------------------
      // Synchronisers
      // ------------------------------------------------------------
      sync1_q <= general_io_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      // ------------------------------------------------------------
      // Write address and data
      // ------------------------------------------------------------
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
        aw_have_q <= 1'b1;
      end
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `UBGP_RESP_OKAY : `UBGP_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl && wstrb_q[0])
      begin
        irq_en_q <= wdata_q[`UBGP_CTRL_IRQ_EN_BIT];
      end
      if (wr_dir && wstrb_q[0])
      begin
        dir_q <= wdata_q[3:0];
      end
      if (wr_out && wstrb_q[0])
      begin
        out_q <= wdata_q[3:0];
      end
      if (wr_func && wstrb_q[0])
      begin
        func_q[7:0] <= wdata_q[7:0];
      end
      if (wr_func && wstrb_q[1])
      begin
        func_q[11:8] <= wdata_q[11:8];
      end
      if (wr_mask && wstrb_q[0])
      begin
        mask_q <= wdata_q[`UBGP_STAT_EDGE_BIT];
      end
      stat_q <= stat_d;
      irq <= stat_d && mask_q;
      // ------------------------------------------------------------
      // Read channel, one cycle after address accept
      // ------------------------------------------------------------
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `UBGP_RESP_OKAY : `UBGP_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      // ------------------------------------------------------------
      // Pins: output drive only for general I/O pins while pipe is open
      // ------------------------------------------------------------
      general_io_o <= out_q;
      general_io_oe <= dir_q & gpio_pin & {4{pipe_on}};
      pin_func <= func_q;
    end
  end

endmodule

/* rtl/ubgp_consts.vh */
// Constants for the four-pin general purpose port block
`ifndef UBGP_CONSTS_VH
`define UBGP_CONSTS_VH

// Register byte offsets
`define UBGP_OFF_CTRL 12'h000
`define UBGP_OFF_DIR 12'h004
`define UBGP_OFF_OUT 12'h008
`define UBGP_OFF_IN 12'h00C
`define UBGP_OFF_FUNC 12'h010
`define UBGP_OFF_STAT 12'h014
`define UBGP_OFF_MASK 12'h018

// Control fields
`define UBGP_CTRL_MODE_LSB 0
`define UBGP_CTRL_MODE_MSB 1
`define UBGP_CTRL_IRQ_EN_BIT 4
`define UBGP_CTRL_FALL_BIT 5

// Configuration modes that open the port pipe
`define UBGP_MODE_ZERO 2'h0
`define UBGP_MODE_ONE 2'h1

// Pin function codes, three bits per pin
`define UBGP_FN_GPIO 3'h0
`define UBGP_FN_SSEL 3'h1
`define UBGP_FN_TWOWIRE 3'h2
`define UBGP_FN_SUSPEND 3'h3
`define UBGP_FN_WAKEUP 3'h4
`define UBGP_FN_IRQ 3'h5

// Status bits
`define UBGP_STAT_EDGE_BIT 0

// Reset values
`define UBGP_RST_WORD 32'h0000_0000
`define UBGP_RST_FUNC 12'h000
`define UBGP_RST_MODE 2'h3

// AXI responses
`define UBGP_RESP_OKAY 2'h0
`define UBGP_RESP_SLVERR 2'h2

`endif

/* test/ubgp_pins_model.sv */
// Board-side model of the four port pins
`timescale 1ns/1ps
module ubgp_pins_model
(
  // Pin levels
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] ext,
  output logic [3:0] pin_i
);
  // Board drives every pin, so a released pin never floats
  assign pin_i = pin_oe & pin_o | ~pin_oe & ext;
endmodule

/* test/ubgp_port_checker.sv */
// Assertions on the port block
`timescale 1ns/1ps
module ubgp_port_checker
(
  // Watched ports
  input wire aclk,
  input wire aresetn,
  input wire [1:0] config_mode,
  input wire nv_edge_fall,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] general_io_i,
  input wire [3:0] general_io_oe,
  input wire [11:0] pin_func,
  input wire irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bh: assert property (p_bh) else $error("bvalid dropped");
  property p_bd; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bd: assert property (p_bd) else $error("bvalid stuck");
  property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rh: assert property (p_rh) else $error("rvalid dropped");
  property p_ar; s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("rvalid late");
  property p_rb; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rb: assert property (p_rb) else $error("read overlap");
  // Mode reaches the pins through two registers
  property p_pipe; (config_mode > 2'h1) [*3] |=> general_io_oe == 4'h0; endproperty
  a_pipe: assert property (p_pipe) else $error("pin driven while closed");
  property p_fn; general_io_oe[3] |-> pin_func[11:9] == 3'h0; endproperty
  a_fn: assert property (p_fn) else $error("alt pin driven");
  // A mask write may also raise irq, so only rises that follow a pin change count
  property p_irq;
    $rose(irq) && ($past(general_io_i[3], 3) != $past(general_io_i[3], 4)) |->
      pin_func[11:9] == 3'h5 && $past(general_io_i[3], 3) != nv_edge_fall;
  endproperty
  a_irq: assert property (p_irq) else $error("wrong edge");
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind ubgp_port ubgp_port_checker chk_u (.*);

/* test/usb_bridge_gpio_port_tb_top.sv */
// Bench for the port block
`timescale 1ns/1ps
module usb_bridge_gpio_port_tb_top;
  logic aclk = 0, rst_n = 0, nv = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [1:0] mode = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [3:0] ext = 0;
  logic [15:0] lf = 16'h48f6;
  wire awr, wr, bv, arr, rv, irq;
  wire [1:0] br, rr;
  wire [31:0] rd;
  wire [3:0] po, poe, pi;
  wire [11:0] pf;
  logic [33:0] rq[$], bq[$];
  int n_errors = 0, total_checks = 0, cyc = 0;
  ubgp_port dut_u (.aclk(aclk), .aresetn(rst_n), .clk_en(1'b1), .config_mode(mode), .nv_edge_fall(nv),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .general_io_i(pi), .general_io_o(po), .general_io_oe(poe),
    .pin_func(pf), .irq(irq));
  ubgp_pins_model pins_u (.pin_o(po), .pin_oe(poe), .ext(ext), .pin_i(pi));
  always #4 aclk = ~aclk;
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string nm, input logic [33:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One bus transfer; e is {resp, data} expected on a read, resp alone on a write
  task automatic bus(input logic w, logic [11:0] a, logic [31:0] d, logic [33:0] e);
    @(posedge aclk);
    if (w)
    begin
      bq.push_back(e);
      awa <= a;
      wd <= d;
      {awv, wv, bry} <= 3'h7;
    end
    else
    begin
      rq.push_back(e);
      ara <= a;
      {arv, rry} <= 2'h3;
    end
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
      if (arr) arv <= 0;
    end
    while (!(w ? bv : rv));
    {bry, rry} <= 2'h0;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (bv && bry) chk("bresp", br, bq.pop_front());
    if (rv && rry) chk("rdata", {rr, rd}, rq.pop_front());
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (12) @(posedge aclk);
    rst_n <= 1;
    bus(0, 12'h000, 0, 34'h0);
    mode <= 2'h2;
    bus(1, 12'h004, 32'hf, 34'h2);
    bus(0, 12'h004, 0, 34'h2_0000_0000);
    bus(0, 12'h100, 0, 34'h2_0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      mode <= {1'b0, i[0]};
      lf = nxt(lf);
      ext <= lf[7:4];
      bus(1, 12'h004, lf[3:0], 0);
      bus(1, 12'h008, lf[11:8], 0);
      repeat (4) @(posedge aclk);
      chk("oe", poe, lf[3:0]);
      chk("out", po & poe, lf[11:8] & lf[3:0]);
      bus(0, 12'h00c, 0, {lf[3:0] & lf[11:8] | ~lf[3:0] & lf[7:4]});
    end
    bus(1, 12'h004, 32'h1, 0);
    for (logic [3:0] f = 0; f < 6; f++)
    begin
      bus(1, 12'h010, f, 0);
      bus(0, 12'h010, 0, f);
      chk("func", pf, f);
      chk("oe0", poe[0], f == 0);
    end
    // Edge choice is read once after reset, so each choice needs a reset
    for (int k = 0; k < 2; k++)
    begin
      rst_n <= 0;
      nv <= k[0];
      ext[3] <= !k[0];
      repeat (12) @(posedge aclk);
      rst_n <= 1;
      bus(1, 12'h010, 32'ha00, 0);
      bus(1, 12'h000, 32'h10, 0);
      bus(0, 12'h000, 0, {k[0], 5'h11});
      for (int j = 0; j < 2; j++)
      begin
        bus(1, 12'h018, !j, 0);
        ext[3] <= k[0];
        repeat (6) @(posedge aclk);
        bus(0, 12'h014, 0, 0);
        ext[3] <= !k[0];
        repeat (6) @(posedge aclk);
        chk("irq", irq, j == 0);
        bus(0, 12'h014, 0, 1);
        bus(0, 12'h014, 0, 1);
        bus(1, 12'h014, 32'h1, 0);
        bus(0, 12'h014, 0, 0);
        chk("irq", irq, 0);
      end
    end
    end_sim();
  end
endmodule
